// *** atc_pkg.sv ***
// package for the adc trigger and sample control block
`default_nettype none
package atc_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] ADDR_TRIG_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_CONV_STAT  = 4'h4;
  localparam logic [3:0] ADDR_TRIG_SRC   = 4'h8;
  // trigger control field positions
  localparam int REFSEL_LSB     = 13;
  localparam int SUSPEND_BIT    = 12;
  localparam int UPD_IEN_BIT    = 11;
  localparam int UPD_RDY_BIT    = 10;
  localparam int SAMPLE_BIT     = 9;
  localparam int CONV_REQ_BIT   = 8;
  localparam int GLB_TRIG_BIT   = 7;
  localparam int INSEL_LSB      = 0;
  localparam int INSEL_W        = 6;
  localparam int INPUT_TRIGGER_SOURCE_W       = 5;
  // reset values
  localparam logic [2:0] REFSEL_RESET = 3'h0;
  localparam logic [5:0] INSEL_RESET  = 6'h00;
  localparam logic [4:0] INPUT_TRIGGER_SOURCE_RESET = 5'h00;
  // trigger source codes: global software trigger, and no trigger source
  localparam logic [4:0] INPUT_TRIGGER_SOURCE_GLOBAL_SW = 5'h02;
  localparam logic [4:0] INPUT_TRIGGER_SOURCE_NONE      = 5'h00;
  // reference routing
  typedef enum logic [2:0] {
    ATC_REF_AVDD_AVSS = 3'h0,
    ATC_REF_EXTH_AVSS = 3'h1,
    ATC_REF_AVDD_EXTL = 3'h2,
    ATC_REF_EXTH_EXTL = 3'h3
  } atc_ref_t;
  typedef struct packed {
    logic hi_external; // 1: ext_ref_high, 0: analog supply
    logic lo_external; // 1: ext_ref_low, 0: analog ground
  } atc_ref_route_t;
  // update-ready tracking states
  typedef enum logic [1:0] {
    ATC_RUN   = 2'b00,
    ATC_DRAIN = 2'b01,
    ATC_READY = 2'b11
  } atc_upd_state_t;
endpackage
`default_nettype wire

// *** atc_adc_tick.sv ***
// adc clock tick generator dividing the core clock
`default_nettype none
module atc_adc_tick #(
  parameter int DIV = 4 // core clocks per adc clock
) (
  input  wire logic i_core_clk, // core clock
  input  wire logic i_srst,     // synchronous reset
  output logic      o_tick      // one-cycle adc clock tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  initial begin
    if (DIV < 1) $error("DIV must be at least 1");
  end
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;
  // free running divider, tick when it wraps
  always_comb begin
    tick_next = (cnt_reg == CW'(DIV - 1));
    cnt_next  = tick_next ? '0 : cnt_reg + CW'(1);
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign o_tick = tick_reg;
endmodule
`default_nettype wire

// *** atc_ctrl.sv ***
// adc trigger, reference select and manual sample control with avalon slave
`default_nettype none
module atc_ctrl #(
  parameter int N_INPUTS = 6, // inputs with a trigger source field
  parameter int N_CORES  = 8, // converter cores reporting busy
  parameter int ADC_DIV  = 4  // core clocks per adc clock
) (
  input  wire logic                i_core_clk,       // core clock 40 MHz
  input  wire logic                i_srst,           // sync reset, high
  input  wire logic [3:0]          i_avs_address,    // byte address
  input  wire logic                i_avs_read,       // read strobe
  input  wire logic                i_avs_write,      // write strobe
  input  wire logic [31:0]         i_avs_writedata,  // write data
  input  wire logic [3:0]          i_avs_byteenable, // byte lanes
  output logic [31:0]              o_avs_readdata,   // read data
  output logic                     o_avs_waitrequest,// wait
  input  wire logic [N_CORES-1:0]  i_core_busy,      // conversions running
  input  wire logic [N_INPUTS-1:0] i_hw_trig,        // hardware triggers
  output logic [N_INPUTS-1:0]      o_input_start,    // per input start pulse
  output logic                     o_single_start,   // single conversion start
  output logic [5:0]               o_single_input,   // input to convert
  output atc_pkg::atc_ref_route_t  o_ref_route,      // reference routing
  output logic                     o_shared_sample,  // shared s&h sample
  output logic                     o_sample_override,// ignore sample count
  output logic                     o_irq             // update-ready interrupt
);
  localparam int SRC_BITS = N_INPUTS * atc_pkg::INPUT_TRIGGER_SOURCE_W;
  initial begin
    if (N_INPUTS < 1 || N_INPUTS > 6) $error("N_INPUTS must be 1..6");
    if (N_CORES < 1) $error("N_CORES must be at least 1");
  end

  logic adc_tick;
  atc_adc_tick #(.DIV(ADC_DIV)) u_tick (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .o_tick     (adc_tick)
  );

  // control register fields
  logic [2:0]          refsel_reg, refsel_next;
  logic                susp_reg, susp_next;
  logic                uien_reg, uien_next;
  logic                manual_sample_hold_reg, manual_sample_hold_next;
  logic                rq_reg, rq_next;
  logic                gtrig_reg, gtrig_next;
  logic [5:0]          insel_reg, insel_next;
  logic [SRC_BITS-1:0] src_reg, src_next;
  // bus answer
  logic                ack_reg, ack_next;
  logic [31:0]         rdata_reg, rdata_next;
  // update-ready tracking
  atc_pkg::atc_upd_state_t upd_reg, upd_next;
  logic                irq_reg, irq_next;
  logic [N_INPUTS-1:0] start_reg, start_next;
  logic                sstart_reg, sstart_next;

  logic req;
  logic wr_ctrl, wr_src;
  logic any_busy;
  logic upd_flag;
  logic [N_INPUTS-1:0] want;
  logic any_start;
  logic [31:0] ctrl_word;
  logic [31:0] wmask;

  assign req      = (i_avs_read | i_avs_write) & ~ack_reg;
  assign wr_ctrl  = req & i_avs_write & (i_avs_address == atc_pkg::ADDR_TRIG_CTRL);
  assign wr_src   = req & i_avs_write & (i_avs_address == atc_pkg::ADDR_TRIG_SRC);
  assign any_busy = |i_core_busy;
  assign upd_flag = (upd_reg == atc_pkg::ATC_READY);
  // byte lane mask for writes
  assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                  {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // per input trigger decode: own hardware trigger or global software trigger
  genvar g;
  generate
    for (g = 0; g < N_INPUTS; g++) begin : g_in
      logic [4:0] src;
      assign src = src_reg[g*atc_pkg::INPUT_TRIGGER_SOURCE_W +: atc_pkg::INPUT_TRIGGER_SOURCE_W];
      assign want[g] =
        (src == atc_pkg::INPUT_TRIGGER_SOURCE_GLOBAL_SW && gtrig_reg) ||
        (src != atc_pkg::INPUT_TRIGGER_SOURCE_NONE &&
         src != atc_pkg::INPUT_TRIGGER_SOURCE_GLOBAL_SW && i_hw_trig[g]);
    end
  endgenerate

  assign any_start = (|start_reg) | sstart_reg;

  // register image of the trigger control word
  always_comb begin
    ctrl_word = '0;
    ctrl_word[atc_pkg::REFSEL_LSB +: 3]   = refsel_reg;
    ctrl_word[atc_pkg::SUSPEND_BIT]       = susp_reg;
    ctrl_word[atc_pkg::UPD_IEN_BIT]       = uien_reg;
    ctrl_word[atc_pkg::UPD_RDY_BIT]       = upd_flag;
    ctrl_word[atc_pkg::SAMPLE_BIT]        = manual_sample_hold_reg;
    ctrl_word[atc_pkg::CONV_REQ_BIT]      = rq_reg;
    ctrl_word[atc_pkg::GLB_TRIG_BIT]      = gtrig_reg;
    ctrl_word[atc_pkg::INSEL_LSB +: atc_pkg::INSEL_W] = insel_reg;
  end

  // software writes and hardware self-clear of the request bit
  always_comb begin
    logic [31:0] w;
    w          = (ctrl_word & ~wmask) | (i_avs_writedata & wmask);
    refsel_next = refsel_reg;
    susp_next   = susp_reg;
    uien_next   = uien_reg;
    manual_sample_hold_next   = manual_sample_hold_reg;
    rq_next     = rq_reg;
    gtrig_next  = gtrig_reg;
    insel_next  = insel_reg;
    src_next    = src_reg;
    // request clears on the adc clock after it was set
    if (rq_reg && adc_tick) begin
      rq_next = 1'b0;
    end
    if (wr_ctrl) begin
      refsel_next = w[atc_pkg::REFSEL_LSB +: 3];
      susp_next   = w[atc_pkg::SUSPEND_BIT];
      uien_next   = w[atc_pkg::UPD_IEN_BIT];
      manual_sample_hold_next   = w[atc_pkg::SAMPLE_BIT];
      gtrig_next  = w[atc_pkg::GLB_TRIG_BIT];
      insel_next  = w[atc_pkg::INSEL_LSB +: atc_pkg::INSEL_W];
      // a fresh write of one wins over the self-clear
      if (w[atc_pkg::CONV_REQ_BIT]) begin
        rq_next = 1'b1;
      end
    end
    if (wr_src) begin
      src_next = (src_reg & ~wmask[SRC_BITS-1:0]) |
                 (i_avs_writedata[SRC_BITS-1:0] & wmask[SRC_BITS-1:0]);
    end
  end

  // start pulses: one per adc clock while the trigger is present and suspend is clear
  always_comb begin
    start_next  = '0;
    sstart_next = 1'b0;
    if (adc_tick && !susp_reg) begin
      start_next  = want;
      sstart_next = rq_reg;
    end
  end

  // update-ready tracking; suspend does not stop running conversions
  always_comb begin
    upd_next = upd_reg;
    unique case (upd_reg)
      atc_pkg::ATC_RUN: begin
        if (susp_reg) upd_next = atc_pkg::ATC_DRAIN;
      end
      atc_pkg::ATC_DRAIN: begin
        if (!susp_reg) upd_next = atc_pkg::ATC_RUN;
        else if (!any_busy && !any_start)
          upd_next = atc_pkg::ATC_READY;
      end
      atc_pkg::ATC_READY: begin
        if (!susp_reg || any_busy || any_start)
          upd_next = atc_pkg::ATC_RUN;
      end
      default: upd_next = atc_pkg::ATC_RUN;
    endcase
    // interrupt level follows the flag's rising edge until it falls
    irq_next = irq_reg;
    if (upd_next != atc_pkg::ATC_READY) begin
      irq_next = 1'b0;
    end else if (!upd_flag) begin
      irq_next = uien_reg;
    end
    if (!uien_reg) irq_next = 1'b0;
  end

  // avalon answer: one wait cycle, then ack with registered data
  always_comb begin
    ack_next   = req;
    rdata_next = rdata_reg;
    if (req && i_avs_read) begin
      unique case (i_avs_address)
        atc_pkg::ADDR_TRIG_CTRL: rdata_next = ctrl_word;
        atc_pkg::ADDR_CONV_STAT: rdata_next = 32'(i_core_busy);
        atc_pkg::ADDR_TRIG_SRC:  rdata_next = 32'(src_reg);
        default:                 rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      refsel_reg <= atc_pkg::REFSEL_RESET;
      susp_reg   <= 1'b0;
      uien_reg   <= 1'b0;
      manual_sample_hold_reg   <= 1'b0;
      rq_reg     <= 1'b0;
      gtrig_reg  <= 1'b0;
      insel_reg  <= atc_pkg::INSEL_RESET;
      src_reg    <= '0;
      ack_reg    <= 1'b0;
      rdata_reg  <= '0;
      upd_reg    <= atc_pkg::ATC_RUN;
      irq_reg    <= 1'b0;
      start_reg  <= '0;
      sstart_reg <= 1'b0;
    end else begin
      refsel_reg <= refsel_next;
      susp_reg   <= susp_next;
      uien_reg   <= uien_next;
      manual_sample_hold_reg   <= manual_sample_hold_next;
      rq_reg     <= rq_next;
      gtrig_reg  <= gtrig_next;
      insel_reg  <= insel_next;
      src_reg    <= src_next;
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      upd_reg    <= upd_next;
      irq_reg    <= irq_next;
      start_reg  <= start_next;
      sstart_reg <= sstart_next;
    end
  end

  // reference routing; reserved codes fall back to supply and ground
  always_comb begin
    o_ref_route = '0;
    unique case (refsel_reg)
      atc_pkg::ATC_REF_EXTH_EXTL: o_ref_route = 2'b11;
      atc_pkg::ATC_REF_AVDD_EXTL: o_ref_route = 2'b01;
      atc_pkg::ATC_REF_EXTH_AVSS: o_ref_route = 2'b10;
      default:                    o_ref_route = 2'b00;
    endcase
  end

  // manual sample drives the shared converter's sample and hold and the sample override
  assign o_shared_sample   = manual_sample_hold_reg;
  assign o_sample_override = manual_sample_hold_reg;
  assign o_input_start     = start_reg;
  assign o_single_start    = sstart_reg;
  assign o_single_input    = insel_reg;
  assign o_irq             = irq_reg;
  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
endmodule
`default_nettype wire

// *** atc_ctrl_monitor.sv ***
// assertion checker for the adc trigger control block
`default_nettype none
module atc_ctrl_monitor #(
  parameter int N_INPUTS = 6, // inputs with a source field
  parameter int N_CORES  = 8  // converter cores
) (
  input wire logic                    i_core_clk,        // clock
  input wire logic                    i_srst,            // sync reset
  input wire logic [3:0]              i_avs_address,     // address
  input wire logic                    i_avs_write,       // write strobe
  input wire logic [31:0]             i_avs_writedata,   // write data
  input wire logic [3:0]              i_avs_byteenable,  // lanes
  input wire logic                    o_avs_waitrequest, // wait
  input wire logic [N_CORES-1:0]      i_core_busy,       // busy cores
  input wire logic [N_INPUTS-1:0]     o_input_start,     // input starts
  input wire logic                    o_single_start,    // single start
  input wire logic [5:0]              o_single_input,    // single input
  input wire atc_pkg::atc_ref_route_t o_ref_route,       // references
  input wire logic                    o_shared_sample,   // sample
  input wire logic                    o_sample_override, // override
  input wire logic                    o_irq              // interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] wd;
  logic        wr0, wr8, susp_reg, susp_next, ien_reg, ien_next;
  logic        src0_reg, src0_next;
  logic [5:0]  sel_reg, sel_next;
  assign wd  = i_avs_writedata;
  assign wr0 = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0;
  assign wr8 = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h8;
  // shadow of written control bits, one edge behind the design on purpose
  always_comb begin
    {susp_next, ien_next, sel_next, src0_next} =
      {susp_reg, ien_reg, sel_reg, src0_reg};
    if (wr0 && i_avs_byteenable[1]) {susp_next, ien_next} = wd[12:11];
    if (wr0 && i_avs_byteenable[0]) sel_next = wd[5:0];
    if (wr8 && i_avs_byteenable == 4'hF)
      src0_next = wd[N_INPUTS*5-1:0] == '0;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) {susp_reg, ien_reg, sel_reg, src0_reg} <= {8'h00, 1'b1};
    else {susp_reg, ien_reg, sel_reg, src0_reg} <=
      {susp_next, ien_next, sel_next, src0_next};
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  sequence s_ctl_wr;
    wr0 && i_avs_byteenable[1];
  endsequence
  sequence s_req_wr;
    s_ctl_wr ##0 (wd[8] && !wd[12]);
  endsequence
  a_ref_route: assert property (s_ctl_wr ##0 !wd[15] |->
    o_ref_route == {wd[13], wd[14]}) else $error("reference route wrong");
  a_sample_follow: assert property (s_ctl_wr |->
    o_shared_sample == wd[9] && o_sample_override == wd[9])
    else $error("sample override wrong");
  a_suspend_blocks: assert property (susp_reg |->
    o_input_start == '0 && !o_single_start) else $error("start in suspend");
  a_request_start: assert property (s_req_wr |-> ##[1:6] o_single_start)
    else $error("no single start");
  a_single_pulse: assert property (o_single_start |=>
    !o_single_start [*3]) else $error("request not cleared");
  a_input_select: assert property (o_single_start |->
    o_single_input == sel_reg) else $error("wrong single input");
  a_irq_enable: assert property ($rose(o_irq) |-> ien_reg && susp_reg)
    else $error("interrupt without enable");
  a_irq_unsusp: assert property (o_irq |-> susp_reg || $past(susp_reg))
    else $error("interrupt outlives suspend");
  a_irq_busy: assert property (o_irq && i_core_busy != '0 |->
    ##[0:2] !o_irq) else $error("interrupt while busy");
  a_no_source: assert property (src0_reg |-> o_input_start == '0)
    else $error("start with no source");
endmodule
bind atc_ctrl atc_ctrl_monitor #(.N_INPUTS(N_INPUTS), .N_CORES(N_CORES))
  mon_u (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_avs_address(i_avs_address), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_waitrequest(o_avs_waitrequest), .i_core_busy(i_core_busy),
  .o_input_start(o_input_start), .o_single_start(o_single_start),
  .o_single_input(o_single_input), .o_ref_route(o_ref_route),
  .o_shared_sample(o_shared_sample), .o_sample_override(o_sample_override),
  .o_irq(o_irq));
`default_nettype wire

// *** atc_core_model.sv ***
// converter core model answering start pulses with busy time
`default_nettype none
module atc_core_model #(
  parameter int N_INPUTS = 6, // start lines
  parameter int N_CORES  = 8  // cores, the last one shared
) (
  input  wire logic                i_core_clk,     // clock
  input  wire logic                i_srst,         // sync reset
  input  wire logic [N_INPUTS-1:0] i_input_start,  // per input start
  input  wire logic                i_single_start, // shared start
  input  wire logic                i_slow,         // long conversions
  output logic      [N_CORES-1:0]  o_core_busy     // running
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_reg  [N_CORES];
  logic [3:0] cnt_next [N_CORES];
  // a running conversion ends on its own count, suspend or not
  always_comb begin
    for (int c = 0; c < N_CORES; c++) begin
      cnt_next[c] = (cnt_reg[c] != 4'h0) ? cnt_reg[c] - 4'h1 : 4'h0;
      if ((c < N_INPUTS && i_input_start[c % N_INPUTS]) ||
          (c == N_CORES - 1 && i_single_start))
        cnt_next[c] = i_slow ? 4'hC : 4'h2;
      o_core_busy[c] = cnt_reg[c] != 4'h0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    for (int c = 0; c < N_CORES; c++)
      cnt_reg[c] <= i_srst ? 4'h0 : cnt_next[c];
  end
endmodule
`default_nettype wire

// *** test_atc_ctrl.sv ***
// self-checking bench for the adc trigger control block
`default_nettype none
module test_atc_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, srst, rd, wr, slow, wt, sst, shs, sov, irq;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdat, exp_d[$], exp_m[$], exp_s[$];
  logic [7:0]  busy;
  logic [5:0]  hw, ist, sin, in_seen;
  int          n_errors, checked, seed, n_in;
  atc_pkg::atc_ref_route_t route;
  atc_ctrl #(.N_INPUTS(6), .N_CORES(8), .ADC_DIV(4)) dut_u (
    .i_core_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_core_busy(busy),
    .i_hw_trig(hw), .o_input_start(ist), .o_single_start(sst),
    .o_single_input(sin), .o_ref_route(route), .o_shared_sample(shs),
    .o_sample_override(sov), .o_irq(irq));
  atc_core_model #(.N_INPUTS(6), .N_CORES(8)) core_u (.i_core_clk(clk),
    .i_srst(srst), .i_input_start(ist), .i_single_start(sst),
    .i_slow(slow), .o_core_busy(busy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, e, m);
    checked++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= r;
    wr <= !r;
    adr <= a;
    wd <= d;
    // waitrequest is judged at the rising edge, as the slave sees it
    do @(posedge clk); while (wt !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [3:0] a, input logic [31:0] e, m);
    exp_d.push_back(e);
    exp_m.push_back(m);
    bus(1'b1, a, 32'h0);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic summarize();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hardware triggers toggle freely; no source field selects them
  always @(posedge clk) hw <= 6'($random(seed));
  // results are matched against the oldest note when they appear
  always @(negedge clk) begin
    if (rd === 1'b1 && wt === 1'b0)
      chk(rdat, exp_d.pop_front(), exp_m.pop_front());
    if (sst === 1'b1) chk(sin, exp_s.size() ? exp_s.pop_front() : 'x, 32'h3F);
    if (ist !== 6'h00) n_in++;
    in_seen = in_seen | ist;
  end
  initial begin
    #(25 * 8000);
    n_errors++;
    $display("MISMATCH t=%0t timeout", $time);
    summarize();
  end
  initial begin
    logic [31:0] v, src;
    {seed, n_errors, checked, n_in, in_seen} = {32'h5d06, 96'h0, 6'h00};
    {srst, rd, wr, slow, adr, be, wd, hw} = {4'h8, 4'h0, 4'hF, 38'h0};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdx(4'h0, 32'h0, 32'h0000FFBF);
    rdx(4'h8, 32'h0, 32'h3FFFFFFF);
    rdx(4'hC, 32'h0, 32'hFFFFFFFF);
    rdx(4'h4, 32'h0, 32'hFFFFFFFF);
    note("reset");
    // reserved codes with the top bit set are never written
    for (int c = 0; c < 4; c++) begin
      bus(1'b0, 4'h0, c << 13);
      chk(route, {c[0], c[1]}, 32'h3);
      rdx(4'h0, c << 13, 32'hE000);
    end
    bus(1'b0, 4'hC, $random(seed));
    rdx(4'h0, 32'h6000, 32'hFFBF);
    note("reference");
    bus(1'b0, 4'h0, 32'h0200);
    chk({shs, sov}, 2'b11, 32'h3);
    bus(1'b0, 4'h0, 32'h0);
    chk({shs, sov}, 2'b00, 32'h3);
    for (int k = 0; k < 3; k++) begin
      v = $random(seed) & 32'h3F;
      exp_s.push_back(v);
      bus(1'b0, 4'h0, 32'h0100 | v);
      repeat (8) @(posedge clk);
      rdx(4'h0, v, 32'h013F);
    end
    chk(exp_s.size(), 0, 32'hFF);
    note("single");
    src = 0;
    for (int i = 0; i < 6; i++) src |= atc_pkg::INPUT_TRIGGER_SOURCE_GLOBAL_SW << (5 * i);
    bus(1'b0, 4'h8, src);
    slow <= 1'b1;
    bus(1'b0, 4'h0, 32'h0080);
    repeat (12) @(posedge clk);
    chk(in_seen, 6'h3F, 32'h3F);
    bus(1'b0, 4'h0, 32'h1880);
    repeat (2) @(posedge clk);
    n_in = 0;
    for (int t = 0; t < 60 && irq !== 1'b1; t++) @(negedge clk);
    chk(irq, 1'b1, 32'h1);
    chk(n_in, 0, 32'hFFFF);
    rdx(4'h0, 32'h1C80, 32'h1F80);
    in_seen = 6'h00;
    bus(1'b0, 4'h0, 32'h0880);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0, 32'h1);
    repeat (10) @(negedge clk);
    chk(in_seen, 6'h3F, 32'h3F);
    note("suspend");
    bus(1'b0, 4'h0, 32'h1000);
    repeat (40) @(negedge clk);
    chk(irq, 1'b0, 32'h1);
    rdx(4'h0, 32'h1400, 32'h1F80);
    bus(1'b0, 4'h8, 32'h0);
    bus(1'b0, 4'h0, 32'h0080);
    in_seen = 6'h00;
    repeat (12) @(negedge clk);
    chk(in_seen, 6'h00, 32'h3F);
    note("no_irq");
    summarize();
  end
endmodule
`default_nettype wire
